/* design/ddr_burst2_sram_port.sv */
// Burst-of-two DDR SRAM port: command decode, posted writes, read pipeline, echo and valid outputs.
`timescale 1ns/1ps
module ddr_burst2_sram_port (
  input wire logic REF_CLK_IN,
  input wire logic RST_IN,
  input wire logic K_CLK_IN,
  input wire logic K_CLK_N_IN,
  input wire logic LOAD_STROBE_N_IN,
  input wire logic DIR_SEL_IN,
  input wire logic [sram_port_pkg::LANES-1:0] BYTE_LANE_MASK_N_IN,
  input wire logic [sram_port_pkg::ADDR_W-1:0] ADDR_IN,
  input wire logic [sram_port_pkg::WORD_W-1:0] DQ_IN,
  output logic [sram_port_pkg::WORD_W-1:0] DQ_OUT,
  output logic DQ_OE_OUT,
  input wire logic LOOP_DISABLE_N_IN,
  input wire logic IMPEDANCE_REF_PIN_IN,
  output logic [sram_port_pkg::IMP_W-1:0] IMP_CODE_OUT,
  output logic ECHO_TIMING_OUT,
  output logic ECHO_TIMING_N_OUT,
  output logic READ_VALID_FLAG_OUT,
  output logic DLL_LOCKED_OUT
);
  sram_port_pkg::pins_t pins;
  sram_port_pkg::pins_t meta_ff;
  sram_port_pkg::pins_t s_ff;
  logic k_d_ff;
  logic kn_d_ff;
  logic k_rise;
  logic kn_rise;
  sram_port_pkg::lock_st_t lock_st_ff;
  logic [11:0] lock_cnt_ff;
  logic cmd_en;
  logic rd_cmd;
  logic wr_cmd;
  logic lat2;
  logic rs1_ff;
  logic rs2_ff;
  logic [sram_port_pkg::ADDR_W-1:0] ra1_ff;
  logic [sram_port_pkg::ADDR_W-1:0] ra2_ff;
  logic launch;
  logic [sram_port_pkg::ADDR_W-1:0] launch_addr;
  logic wp_ff;
  logic w2_ff;
  logic [sram_port_pkg::ADDR_W-1:0] wa_cmd_ff;
  sram_port_pkg::wr_slot_t cur_ff;
  sram_port_pkg::wr_slot_t post_ff;
  logic post_v_ff;
  logic commit;
  sram_port_pkg::rd_pair_t mem_ff [sram_port_pkg::MEM_DEPTH];
  sram_port_pkg::rd_pair_t fetch;
  logic [sram_port_pkg::MEM_AW-1:0] post_idx;
  logic buf_in_ready;
  logic buf_out_valid;
  sram_port_pkg::rd_pair_t buf_out;
  logic pop;
  logic sec_pend_ff;
  logic [sram_port_pkg::WORD_W-1:0] sec_word_ff;
  logic [sram_port_pkg::WORD_W-1:0] dq_ff;
  logic oe_ff;
  logic qv_ff;
  logic echo_ff;
  logic echo_n_ff;
  logic [9:0] imp_cnt_ff;
  logic [sram_port_pkg::IMP_W-1:0] imp_ff;

  // Overlay the lane-enabled words of a held burst onto an older pair.
  function automatic sram_port_pkg::rd_pair_t merge(input sram_port_pkg::rd_pair_t old,
                                                    input sram_port_pkg::wr_slot_t w);
    sram_port_pkg::rd_pair_t r;
    logic [sram_port_pkg::WORD_W-1:0] e0;
    logic [sram_port_pkg::WORD_W-1:0] e1;
    e0 = sram_port_pkg::lane_bits(w.m0);
    e1 = sram_port_pkg::lane_bits(w.m1);
    r.w0 = (old.w0 & ~e0) | (w.d0 & e0);
    r.w1 = (old.w1 & ~e1) | (w.d1 & e1);
    return r;
  endfunction

  assign pins = '{k: K_CLK_IN, kn: K_CLK_N_IN, ld_n: LOAD_STROBE_N_IN, dir: DIR_SEL_IN,
                  mask_n: BYTE_LANE_MASK_N_IN, d: DQ_IN, addr: ADDR_IN,
                  loop_dis_n: LOOP_DISABLE_N_IN, imp_hi: IMPEDANCE_REF_PIN_IN};

  // Everything on the link is asynchronous to REF_CLK_IN, so all pins share one two-stage synchroniser.
  // The link clock is slow enough that data and strobes settle long before a sampled edge is used.
  always_ff @(posedge REF_CLK_IN)
  begin
    meta_ff <= pins;
    s_ff <= meta_ff;
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      // Seeding the edge registers from the live pins stops a false edge right after reset.
      k_d_ff <= s_ff.k;
      kn_d_ff <= s_ff.kn;
    end
    else
    begin
      k_d_ff <= s_ff.k;
      kn_d_ff <= s_ff.kn;
    end
  end

  assign k_rise = s_ff.k && !k_d_ff;
  assign kn_rise = s_ff.kn && !kn_d_ff;

  // Commands are refused until the loop has locked, or at once when the loop is disabled.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      lock_st_ff <= sram_port_pkg::ST_COLD;
      lock_cnt_ff <= '0;
    end
    else
    begin
      case (lock_st_ff)
        sram_port_pkg::ST_COLD:
        begin
          lock_cnt_ff <= '0;
          if (k_rise)
          begin
            lock_st_ff <= s_ff.loop_dis_n ? sram_port_pkg::ST_LOCKING : sram_port_pkg::ST_READY;
          end
        end
        sram_port_pkg::ST_LOCKING:
        begin
          if (!s_ff.loop_dis_n)
          begin
            lock_st_ff <= sram_port_pkg::ST_READY;
          end
          else if (k_rise)
          begin
            lock_cnt_ff <= lock_cnt_ff + 12'h0001;
            if (lock_cnt_ff == sram_port_pkg::LOCK_LAST)
            begin
              lock_st_ff <= sram_port_pkg::ST_READY;
            end
          end
        end
        sram_port_pkg::ST_READY:
        begin
          lock_st_ff <= sram_port_pkg::ST_READY;
        end
        default:
        begin
          lock_st_ff <= sram_port_pkg::ST_COLD;
        end
      endcase
    end
  end

  assign cmd_en = (lock_st_ff == sram_port_pkg::ST_READY);
  assign rd_cmd = cmd_en && k_rise && !s_ff.ld_n && (s_ff.dir == sram_port_pkg::DIR_READ);
  assign wr_cmd = cmd_en && k_rise && !s_ff.ld_n && (s_ff.dir != sram_port_pkg::DIR_READ);
  assign lat2 = s_ff.loop_dis_n;

  // Read address pipeline; one stage per positive rise gives latency one or two.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
      ra1_ff <= '0;
      ra2_ff <= '0;
    end
    else if (k_rise)
    begin
      rs1_ff <= rd_cmd;
      ra1_ff <= s_ff.addr;
      rs2_ff <= rs1_ff;
      ra2_ff <= ra1_ff;
    end
  end

  assign launch = lat2 ? rs2_ff : rs1_ff;
  assign launch_addr = lat2 ? ra2_ff : ra1_ff;

  // Write data path: address at the command rise, word one at the next rise, word two at the falling half.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      wp_ff <= 1'b0;
      w2_ff <= 1'b0;
      wa_cmd_ff <= '0;
      cur_ff <= '0;
    end
    else if (k_rise)
    begin
      wp_ff <= wr_cmd;
      if (wr_cmd)
      begin
        wa_cmd_ff <= s_ff.addr;
      end
      if (wp_ff)
      begin
        cur_ff.addr <= wa_cmd_ff;
        cur_ff.d0 <= s_ff.d;
        cur_ff.m0 <= ~s_ff.mask_n;
      end
      w2_ff <= wp_ff;
    end
    else if (kn_rise && w2_ff)
    begin
      w2_ff <= 1'b0;
    end
  end

  assign post_idx = post_ff.addr[sram_port_pkg::MEM_AW-1:0];

  // The finished burst is held until the next write command, or until a newer burst needs the register.
  // Holding every burst this way keeps the array port free during reads, at the cost of the bypass compare and merge on fetch.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      post_v_ff <= 1'b0;
      post_ff <= '0;
    end
    else if (kn_rise && w2_ff)
    begin
      post_v_ff <= 1'b1;
      post_ff <= '{addr: cur_ff.addr, d0: cur_ff.d0, d1: s_ff.d, m0: cur_ff.m0, m1: ~s_ff.mask_n};
    end
    else if (wr_cmd)
    begin
      post_v_ff <= 1'b0;
    end
  end

  // A held burst is written out before a newer one takes its place, so back-to-back writes lose nothing.
  assign commit = post_v_ff && (wr_cmd || (kn_rise && w2_ff));

  // The array keeps only the low address bits; upper address bits alias onto it.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!RST_IN && commit)
    begin
      mem_ff[post_idx] <= merge(mem_ff[post_idx], post_ff);
    end
  end

  always_comb
  begin
    fetch = mem_ff[launch_addr[sram_port_pkg::MEM_AW-1:0]];
    // Only the index bits are compared, because upper address bits alias onto the same location.
    if (post_v_ff && (post_idx == launch_addr[sram_port_pkg::MEM_AW-1:0]))
    begin
      fetch = merge(fetch, post_ff);
    end
  end

  pair_buf #(
    .WIDTH($bits(sram_port_pkg::rd_pair_t)),
    .DEPTH(sram_port_pkg::BUF_DEPTH)
  ) u_rd_buf (
    .clk_in(REF_CLK_IN),
    .rst_in(RST_IN),
    .in_valid_in(k_rise && launch),
    .in_ready_out(buf_in_ready),
    .in_data_in(fetch),
    .out_valid_out(buf_out_valid),
    .out_ready_in(!sec_pend_ff),
    .out_data_out(buf_out)
  );

  assign pop = buf_out_valid && !sec_pend_ff;

  // Output serializer: the second word waits for the complementary rise before the next pair is taken.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      sec_pend_ff <= 1'b0;
      sec_word_ff <= '0;
      dq_ff <= '0;
      oe_ff <= 1'b0;
    end
    else if (pop)
    begin
      dq_ff <= buf_out.w0;
      sec_word_ff <= buf_out.w1;
      sec_pend_ff <= 1'b1;
      oe_ff <= 1'b1;
    end
    else if (kn_rise && sec_pend_ff)
    begin
      dq_ff <= sec_word_ff;
      sec_pend_ff <= 1'b0;
    end
    else if (k_rise && !launch && !sec_pend_ff && !buf_out_valid)
    begin
      oe_ff <= 1'b0;
    end
  end

  // Valid rises at the complementary edge before launch and falls when the last word ends.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      qv_ff <= 1'b0;
    end
    else if (k_rise)
    begin
      qv_ff <= launch;
    end
    else if (kn_rise)
    begin
      qv_ff <= qv_ff || launch;
    end
  end

  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      echo_ff <= 1'b0;
      echo_n_ff <= 1'b0;
    end
    else
    begin
      echo_ff <= s_ff.k;
      echo_n_ff <= s_ff.kn;
    end
  end

  // The impedance code steps one unit per period toward the reference comparator's verdict.
  always_ff @(posedge REF_CLK_IN)
  begin
    if (RST_IN)
    begin
      imp_cnt_ff <= '0;
      imp_ff <= sram_port_pkg::IMP_RST;
    end
    else if (k_rise)
    begin
      imp_cnt_ff <= imp_cnt_ff + 10'h001;
      if (imp_cnt_ff == sram_port_pkg::IMP_LAST)
      begin
        if (s_ff.imp_hi && imp_ff != sram_port_pkg::IMP_MAX)
        begin
          imp_ff <= imp_ff + 4'h1;
        end
        else if (!s_ff.imp_hi && imp_ff != sram_port_pkg::IMP_MIN)
        begin
          imp_ff <= imp_ff - 4'h1;
        end
      end
    end
  end

  assign DQ_OUT = dq_ff;
  assign DQ_OE_OUT = oe_ff;
  assign READ_VALID_FLAG_OUT = qv_ff;
  assign ECHO_TIMING_OUT = echo_ff;
  assign ECHO_TIMING_N_OUT = echo_n_ff;
  assign IMP_CODE_OUT = imp_ff;
  assign DLL_LOCKED_OUT = cmd_en;

  default clocking cb @(posedge REF_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  a_cmd_on_krise: assert property ($changed(rs1_ff) |-> $past(k_rise))
    else $error("read pipeline moved without a positive rise");
  a_read_word_launch: assert property (k_rise && launch |-> ##[1:3] (oe_ff && sec_pend_ff))
    else $error("first read word not launched after its latency");
  a_second_word: assert property (kn_rise && sec_pend_ff && !pop |=> dq_ff == $past(sec_word_ff))
    else $error("second burst word not driven on complementary rise");
  a_float_after: assert property (k_rise && !launch && !sec_pend_ff && !buf_out_valid |=> !oe_ff)
    else $error("outputs still driven after reads stopped");
  a_buf_room: assert property (k_rise && launch |-> buf_in_ready)
    else $error("read pair arrived while the output buffer was full");
  a_write_addr_cap: assert property (wr_cmd |=> wa_cmd_ff == $past(s_ff.addr) && wp_ff)
    else $error("write address not captured");
  a_burst_held: assert property (kn_rise && w2_ff |=> post_v_ff && post_ff.addr == $past(cur_ff.addr))
    else $error("finished write burst not held");
  a_lane_keep: assert property (commit && post_ff.m0 == 2'h0
                                |=> mem_ff[$past(post_idx)].w0 == $past(mem_ff[post_idx].w0))
    else $error("unselected lanes were altered");
  a_valid_early: assert property (kn_rise && launch && !k_rise |=> qv_ff)
    else $error("read valid not raised before first word");
  a_lock_time: assert property ($rose(cmd_en) && lat2 |-> $past(lock_cnt_ff) == sram_port_pkg::LOCK_LAST)
    else $error("lock reached at wrong count");
  a_imp_period: assert property ($changed(imp_ff) |-> $past(imp_cnt_ff) == sram_port_pkg::IMP_LAST)
    else $error("impedance code changed off period");
endmodule

/* design/pair_buf.sv */
// Two-entry valid/ready buffer built from flip-flops.
`timescale 1ns/1ps
module pair_buf #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_idx_ff;
  logic [$clog2(DEPTH)-1:0] rd_idx_ff;
  logic [$clog2(DEPTH):0] cnt_ff;
  logic push;
  logic pop;

  assign in_ready_out = (cnt_ff != DEPTH[$clog2(DEPTH):0]);
  assign out_valid_out = (cnt_ff != '0);
  assign out_data_out = slot_ff[rd_idx_ff];
  assign push = in_valid_in && in_ready_out;
  assign pop = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (push)
    begin
      slot_ff[wr_idx_ff] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wr_idx_ff <= '0;
      rd_idx_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_idx_ff <= wr_idx_ff + 1'b1;
      end
      if (pop)
      begin
        rd_idx_ff <= rd_idx_ff + 1'b1;
      end
      if (push && !pop)
      begin
        cnt_ff <= cnt_ff + 1'b1;
      end
      else if (pop && !push)
      begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule

/* design/sram_port_pkg.sv */
// Shared constants, carrier structs and helpers for the burst-of-two DDR SRAM port.
package sram_port_pkg;
  localparam int WORD_W = 18;
  localparam int ADDR_W = 20;
  localparam int MEM_AW = 4;
  localparam int MEM_DEPTH = 16;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int IMP_W = 4;
  localparam int BUF_DEPTH = 2;
  // Counts are in rising edges of the positive link clock.
  localparam int LOCK_CYC = 2048;
  localparam int IMP_PERIOD = 1024;
  localparam logic [11:0] LOCK_LAST = 12'h0800 - 12'h0001;
  localparam logic [9:0] IMP_LAST = 10'h3ff;
  localparam logic [IMP_W-1:0] IMP_RST = 4'h8;
  localparam logic [IMP_W-1:0] IMP_MAX = 4'hf;
  localparam logic [IMP_W-1:0] IMP_MIN = 4'h0;
  localparam logic DIR_READ = 1'b1;

  typedef enum logic [1:0]
  {
    ST_COLD = 2'b00,
    ST_LOCKING = 2'b01,
    ST_READY = 2'b10
  } lock_st_t;

  // Every pin that arrives from the controller's side.
  typedef struct packed
  {
    logic k;
    logic kn;
    logic ld_n;
    logic dir;
    logic [LANES-1:0] mask_n;
    logic [WORD_W-1:0] d;
    logic [ADDR_W-1:0] addr;
    logic loop_dis_n;
    logic imp_hi;
  } pins_t;

  // One finished write burst; lane enables are active high here.
  typedef struct packed
  {
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] d0;
    logic [WORD_W-1:0] d1;
    logic [LANES-1:0] m0;
    logic [LANES-1:0] m1;
  } wr_slot_t;

  typedef struct packed
  {
    logic [WORD_W-1:0] w1;
    logic [WORD_W-1:0] w0;
  } rd_pair_t;

  function automatic logic [WORD_W-1:0] lane_bits(input logic [LANES-1:0] en);
    logic [WORD_W-1:0] r;
    r = '0;
    for (int i = 0; i < LANES; i++)
    begin
      r[i*LANE_W +: LANE_W] = {LANE_W{en[i]}};
    end
    return r;
  endfunction
endpackage

/* verif/sram_ctrl_model.sv */
// Model of the memory controller: free-running link clocks, commands and write data.
`timescale 1ns/1ps
module sram_ctrl_model (
  input wire logic ref_clk_in,
  output logic k_out,
  output logic kn_out,
  output logic ld_n_out,
  output logic dir_out,
  output logic [sram_port_pkg::LANES-1:0] mask_n_out,
  output logic [sram_port_pkg::WORD_W-1:0] d_out,
  output logic [sram_port_pkg::ADDR_W-1:0] addr_out
);
  logic [1:0] ph = 2'h0;
  logic pw = 1'b0;
  logic [35:0] pd = 36'h0_0000_0000;
  logic [3:0] pm = 4'h0;
  int since_rd = 9;

  // The odd start offset keeps link clock edges away from system clock edges.
  initial
  begin
    {ld_n_out, dir_out, mask_n_out, d_out, addr_out} = {1'b1, 41'h0};
    #1.3;
    forever
    begin
      #40;
      ph = ph + 2'h1;
    end
  end
  assign k_out = ~ph[1];
  assign kn_out = ph[1];

  task automatic wait_ph(input logic [1:0] p);
    do
      @(ph);
    while (ph != p);
    @(negedge ref_clk_in);
  endtask

  // Lines with nothing to carry show the inverse of their last value, never a stale copy.
  task automatic put(input logic ld_n, input logic dir, input logic [19:0] a, input logic [35:0] d,
    input logic [3:0] mn);
    wait_ph(2'h3);
    ld_n_out = ld_n;
    dir_out = ld_n ? ~dir_out : dir;
    addr_out = ld_n ? ~addr_out : a;
    d_out = pw ? pd[35:18] : ~d_out;
    mask_n_out = pw ? pm[3:2] : ~mask_n_out;
    wait_ph(2'h1);
    d_out = pw ? pd[17:0] : ~d_out;
    mask_n_out = pw ? pm[1:0] : ~mask_n_out;
    pw = !ld_n && !dir;
    pd = d;
    pm = mn;
  endtask

  task automatic slot(input logic ld_n, input logic dir, input logic [19:0] a, input logic [35:0] d,
    input logic [3:0] mn);
    while (!ld_n && !dir && since_rd < 2)
    begin
      put(1'b1, 1'b0, a, d, mn);
      since_rd++;
    end
    put(ld_n, dir, a, d, mn);
    since_rd = (!ld_n && dir) ? 0 : since_rd + 1;
  endtask
endmodule

/* verif/tb_top.sv */
// Self-checking testbench for the burst-of-two DDR SRAM port.
`timescale 1ns/1ps
module tb_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic loop_n = 1'b1;
  logic imp_ref = 1'b1;
  logic mon_on = 1'b0;
  logic k, kn, ld_n, dir, oe, echo, echo_n, vld, locked;
  logic [1:0] mask_n;
  logic [17:0] d, dq;
  logic [19:0] addr;
  logic [3:0] imp;
  int errors = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0000_0025;
  logic [17:0] mem [16][2];
  logic [17:0] expq [$];

  sram_ctrl_model ctrl (.ref_clk_in(ref_clk), .k_out(k), .kn_out(kn), .ld_n_out(ld_n), .dir_out(dir),
    .mask_n_out(mask_n), .d_out(d), .addr_out(addr));
  ddr_burst2_sram_port uut (.REF_CLK_IN(ref_clk), .RST_IN(rst), .K_CLK_IN(k), .K_CLK_N_IN(kn),
    .LOAD_STROBE_N_IN(ld_n), .DIR_SEL_IN(dir), .BYTE_LANE_MASK_N_IN(mask_n), .ADDR_IN(addr), .DQ_IN(d),
    .DQ_OUT(dq), .DQ_OE_OUT(oe), .LOOP_DISABLE_N_IN(loop_n), .IMPEDANCE_REF_PIN_IN(imp_ref),
    .IMP_CODE_OUT(imp), .ECHO_TIMING_OUT(echo), .ECHO_TIMING_N_OUT(echo_n), .READ_VALID_FLAG_OUT(vld),
    .DLL_LOCKED_OUT(locked));

  always #2.5 ref_clk = ~ref_clk;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [35:0] rnd36();
    logic [63:0] v;
    v = {rnd(), rnd()};
    return v[35:0];
  endfunction

  function automatic logic [17:0] merge(input logic [17:0] o, input logic [17:0] n, input logic [1:0] mn);
    return {mn[1] ? o[17:9] : n[17:9], mn[0] ? o[8:0] : n[8:0]};
  endfunction

  task automatic cmp_word(input logic [17:0] e, input logic [17:0] g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: expected %h, got %h", $time, e, g);
    end
  endtask

  task automatic cmp_bit(input logic e, input logic g);
    num_checks++;
    if (g !== e)
    begin
      errors++;
      $display("Error at %0t: expected %h, got %h", $time, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // The model applies lane enables at once; posted and bypassed data must look the same.
  task automatic wr(input logic [19:0] a, input logic [35:0] v, input logic [3:0] mn);
    mem[a[3:0]][0] = merge(mem[a[3:0]][0], v[35:18], mn[3:2]);
    mem[a[3:0]][1] = merge(mem[a[3:0]][1], v[17:0], mn[1:0]);
    ctrl.slot(1'b0, 1'b0, a, v, mn);
  endtask

  task automatic rd(input logic [19:0] a);
    expq.push_back(mem[a[3:0]][0]);
    expq.push_back(mem[a[3:0]][1]);
    ctrl.slot(1'b0, 1'b1, a, 36'h0_0000_0000, 4'h0);
  endtask

  task automatic nop(input int n);
    repeat (n) ctrl.slot(1'b1, 1'b0, 20'h0_0000, 36'h0_0000_0000, 4'h0);
  endtask

  task automatic do_reset(input logic loop);
    mon_on = 1'b0;
    @(negedge ref_clk);
    rst = 1'b1;
    loop_n = loop;
    repeat (10) @(negedge ref_clk);
    cmp_bit(1'b0, oe);
    cmp_bit(1'b0, echo);
    cmp_word(18'h0_0008, {14'h0000, imp});
    rst = 1'b0;
    repeat (10) @(negedge ref_clk);
    mon_on = 1'b1;
  endtask

  initial
  begin
    logic pv;
    logic po;
    pv = 1'b0;
    po = 1'b0;
    forever
    begin
      @(ctrl.ph);
      #20;
      if (mon_on && ctrl.ph[0])
      begin
        cmp_bit(~ctrl.ph[1], echo);
        cmp_bit(ctrl.ph[1], echo_n);
        if (oe === 1'b1)
        begin
          if (po !== 1'b1)
            cmp_bit(1'b1, pv);
          cmp_word(expq.size() > 0 ? expq.pop_front() : ~dq, dq);
        end
        else
          cmp_bit(1'b0, oe | (vld & ~ctrl.ph[1]));
        pv = vld;
        po = oe;
      end
    end
  end

  initial
  begin
    #450_000;
    errors++;
    $display("Error at %0t: expected %h, got %h", $time, 1'b1, 1'b0);
    end_of_test();
  end

  initial
  begin
    logic [31:0] r;
    do_reset(1'b1);
    repeat (1030) @(posedge k);
    cmp_word(18'h0_0009, {14'h0000, imp});
    @(negedge ref_clk);
    imp_ref = 1'b0;
    repeat (1010) @(posedge k);
    cmp_bit(1'b0, locked);
    repeat (20) @(posedge k);
    cmp_bit(1'b1, locked);
    cmp_word(18'h0_0008, {14'h0000, imp});
    $display("test lock done");
    for (int i = 0; i < 16; i++)
      wr(20'(i), rnd36(), 4'h0);
    nop(1);
    for (int i = 0; i < 16; i++)
      rd(20'(i));
    nop(4);
    $display("test burst done");
    for (int i = 0; i < 16; i++)
      wr(20'(i) | 20'h1_0000, rnd36(), 4'(i));
    nop(1);
    for (int i = 0; i < 16; i++)
      rd(20'(i));
    nop(4);
    $display("test lanes done");
    wr(20'h0_0005, rnd36(), 4'h0);
    rd(20'h0_0005);
    rd(20'h0_0006);
    wr(20'h0_0007, rnd36(), 4'h6);
    nop(1);
    rd(20'h0_0005);
    nop(4);
    $display("test posted done");
    for (int i = 0; i < 80; i++)
    begin
      r = rnd();
      if (r[1:0] == 2'h0)
        nop(1);
      else if (r[1:0] == 2'h1)
        rd(r[31:12]);
      else
        wr(r[31:12], rnd36(), r[7:4]);
    end
    nop(4);
    cmp_bit(1'b1, expq.size() == 0);
    $display("test random done");
    do_reset(1'b0);
    repeat (4) @(posedge k);
    cmp_bit(1'b1, locked);
    wr(20'h0_0003, rnd36(), 4'h0);
    rd(20'h0_0003);
    rd(20'h0_0003);
    nop(4);
    cmp_bit(1'b1, expq.size() == 0);
    $display("test short latency done");
    end_of_test();
  end
endmodule
